/* File: src/cab_pkg.sv */
// Shared constants and types of the ALU and branch execution core.
package cab_pkg;

  // Instruction word layout of the core's own fetch format.
  localparam int CAB_OP_HI = 31;
  localparam int CAB_OP_LO = 26;
  localparam int CAB_LONG_BIT = 25;
  localparam int CAB_DST_HI = 24;
  localparam int CAB_DST_LO = 20;
  localparam int CAB_SRC_HI = 19;
  localparam int CAB_SRC_LO = 15;
  localparam int CAB_BIT_HI = 14;
  localparam int CAB_BIT_LO = 12;
  localparam int CAB_K_HI = 11;

  // Flag register bit positions.
  localparam int CAB_FLG_C = 0;
  localparam int CAB_FLG_Z = 1;
  localparam int CAB_FLG_N = 2;
  localparam int CAB_FLG_V = 3;
  localparam int CAB_FLG_S = 4;
  localparam int CAB_FLG_H = 5;
  localparam int CAB_FLG_T = 6;
  localparam int CAB_FLG_I = 7;

  localparam logic [7:0] CAB_MASK_ARITH = 8'h2F;
  localparam logic [7:0] CAB_MASK_LOGIC = 8'h0E;
  localparam logic [7:0] CAB_MASK_INV = 8'h0F;
  localparam logic [7:0] CAB_MASK_WORD = 8'h1F;

  // Register port map.
  localparam logic [7:0] CAB_REG_CTRL = 8'h00;
  localparam logic [7:0] CAB_REG_FLAGS = 8'h01;
  localparam logic [7:0] CAB_REG_PC_LO = 8'h02;
  localparam logic [7:0] CAB_REG_PC_HI = 8'h03;
  localparam logic [2:0] CAB_REG_GPR_PAGE = 3'h1;

  localparam logic [15:0] CAB_PC_RST = 16'h0000;
  localparam logic [7:0] CAB_FLAGS_RST = 8'h00;
  localparam logic CAB_RUN_RST = 1'b0;

  // Total clock counts of the multi-cycle instructions.
  localparam int CAB_CYC_WORD = 2;
  localparam int CAB_CYC_JUMP = 2;
  localparam int CAB_CYC_CALL = 3;
  localparam int CAB_CYC_RETURN = 4;
  localparam int CAB_CYC_TAKEN = 2;

  localparam logic [4:0] CAB_Z_LO = 5'h1E;
  localparam logic [4:0] CAB_Z_HI = 5'h1F;

  typedef enum logic [5:0] {
    op_nop, op_add, op_add_carry, op_word_add_imm, op_minus_reg, op_minus_imm,
    op_minus_carry_reg, op_minus_carry_imm, op_word_minus_imm, op_and_reg,
    op_conj_imm, op_or_reg, op_disj_imm, op_xor_reg, op_bitwise_invert,
    op_arith_invert, op_set_mask_bits, op_clear_mask_bits, op_plus_one,
    op_minus_one, op_zero_sign_check, op_zero_reg, op_all_ones_reg,
    op_rel_jump, op_ptr_jump, op_rel_subroutine_call, op_ptr_subroutine_call,
    op_proc_exit, op_irq_exit, op_equal_skip, op_comparison,
    op_comparison_carry, op_comparison_imm, op_reg_bit_clear_skip,
    op_reg_bit_set_skip, op_io_bit_clear_skip, op_io_bit_set_skip,
    op_flag_set_branch, op_flag_clear_branch
  } cab_op_t;

  typedef enum logic [3:0] {
    alu_add, alu_sub, alu_and, alu_or, alu_xor, alu_inv, alu_negate,
    alu_inc, alu_decr, alu_wadd, alu_wsub
  } cab_alu_op_t;

  typedef enum logic [1:0] {st_exec, st_wait, st_skip, st_pop} cab_state_t;

endpackage

/* File: src/cab_alu_if.sv */
// Bundle between the execution core and its arithmetic unit.
`timescale 1ns/1ps
`default_nettype none
interface cab_alu_if;
  import cab_pkg::*;
  cab_alu_op_t op;
  logic [7:0] a;
  logic [7:0] b;
  logic cin;
  logic [15:0] aw;
  logic [15:0] res;
  logic [7:0] fl;
  logic [7:0] fmask;
  modport core (output op, output a, output b, output cin, output aw,
                input res, input fl, input fmask);
  modport alu (input op, input a, input b, input cin, input aw,
               output res, output fl, output fmask);
endinterface
`default_nettype wire

/* File: src/cab_alu.sv */
// Combinational arithmetic unit with flag generation.
`timescale 1ns/1ps
`default_nettype none
module cab_alu
  import cab_pkg::*;
(
  cab_alu_if.alu port
);

  // Returns {half carry, overflow, carry, result}; carry means borrow on subtraction.
  function automatic logic [10:0] cab_addsub(input logic [7:0] a, input logic [7:0] b,
                                             input logic ci, input logic sub);
    logic [8:0] r;
    logic [4:0] lo;
    logic v;
    if (sub) begin
      r = {1'b0, a} - {1'b0, b} - {8'h00, ci};
      lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
      v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    end else begin
      r = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      v = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
    end
    return {lo[4], v, r[8], r[7:0]};
  endfunction

  always_comb begin
    logic [10:0] q;
    logic [16:0] w;
    logic word;
    q = 11'h000;
    w = 17'h00000;
    word = 1'b0;
    port.fmask = CAB_MASK_ARITH;
    unique case (port.op)
      alu_add: q = cab_addsub(port.a, port.b, port.cin, 1'b0);
      alu_sub: q = cab_addsub(port.a, port.b, port.cin, 1'b1);
      alu_negate: begin
        q = cab_addsub(8'h00, port.a, 1'b0, 1'b1);
        port.fmask = CAB_MASK_INV | CAB_MASK_ARITH;
      end
      alu_inc: begin
        q = cab_addsub(port.a, 8'h01, 1'b0, 1'b0);
        port.fmask = CAB_MASK_LOGIC;
      end
      alu_decr: begin
        q = cab_addsub(port.a, 8'h01, 1'b0, 1'b1);
        port.fmask = CAB_MASK_LOGIC;
      end
      alu_and: begin
        q = {3'b000, port.a & port.b};
        port.fmask = CAB_MASK_LOGIC;
      end
      alu_or: begin
        q = {3'b000, port.a | port.b};
        port.fmask = CAB_MASK_LOGIC;
      end
      alu_xor: begin
        q = {3'b000, port.a ^ port.b};
        port.fmask = CAB_MASK_LOGIC;
      end
      alu_inv: begin
        q = {3'b001, 8'hFF - port.a};
        port.fmask = CAB_MASK_INV;
      end
      alu_wadd: begin
        w = {1'b0, port.aw} + {9'h000, port.b};
        word = 1'b1;
        port.fmask = CAB_MASK_WORD;
      end
      alu_wsub: begin
        w = {1'b0, port.aw} - {9'h000, port.b};
        word = 1'b1;
        port.fmask = CAB_MASK_WORD;
      end
    endcase
    port.fl = 8'h00;
    if (word) begin
      port.res = w[15:0];
      port.fl[CAB_FLG_C] = w[16];
      port.fl[CAB_FLG_Z] = (w[15:0] == 16'h0000);
      port.fl[CAB_FLG_N] = w[15];
      port.fl[CAB_FLG_V] = (port.op == alu_wadd) ? (~port.aw[15] & w[15]) : (port.aw[15] & ~w[15]);
    end else begin
      port.res = {8'h00, q[7:0]};
      port.fl[CAB_FLG_C] = q[8];
      port.fl[CAB_FLG_Z] = (q[7:0] == 8'h00);
      port.fl[CAB_FLG_N] = q[7];
      port.fl[CAB_FLG_V] = q[9];
      port.fl[CAB_FLG_H] = q[10];
    end
    port.fl[CAB_FLG_S] = port.fl[CAB_FLG_N] ^ port.fl[CAB_FLG_V];
  end

endmodule
`default_nettype wire

/* File: src/cab_core.sv */
// Execution core for arithmetic, logic, compare, skip, jump, call and branch instructions.
`timescale 1ns/1ps
`default_nettype none
module cab_core
  import cab_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [31:0] pm_data_i,
  input wire logic [31:0][7:0] io_low_i,
  input wire logic [15:0] stack_top_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  output logic [15:0] pm_addr_o,
  output logic stack_push_o,
  output logic stack_pop_o,
  output logic [15:0] stack_data_o,
  output logic irq_enable_o,
  output logic [7:0] bus_rdata_o
);

  typedef struct packed {
    cab_state_t st;
    logic [1:0] wait_n;
    logic run;
    logic [15:0] pc;
    logic [7:0] flags;
    logic [31:0][7:0] gpr;
    logic [7:0] rdata;
    logic push;
    logic pop;
    logic [15:0] push_data;
  } cab_core_state_t;

  cab_core_state_t s;
  cab_core_state_t next_s;
  logic [1:0] rst_q;
  cab_alu_if alu_bus ();

  cab_alu u_alu (
    .port(alu_bus)
  );

  // The reset is released through two flops so that every state flop leaves reset on the same edge.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end

  function automatic logic [15:0] cab_rel(input logic [15:0] pc, input logic [11:0] k);
    return pc + {{4{k[11]}}, k} + 16'h0001;
  endfunction

  function automatic logic [7:0] cab_reg_rd(input cab_core_state_t st, input logic [7:0] addr);
    logic [7:0] d;
    d = 8'h00;
    if (addr == CAB_REG_CTRL) begin
      d = {7'h00, st.run};
    end else if (addr == CAB_REG_FLAGS) begin
      d = st.flags;
    end else if (addr == CAB_REG_PC_LO) begin
      d = st.pc[7:0];
    end else if (addr == CAB_REG_PC_HI) begin
      d = st.pc[15:8];
    end else if (addr[7:5] == CAB_REG_GPR_PAGE) begin
      d = st.gpr[addr[4:0]];
    end
    return d;
  endfunction

  always_comb begin
    cab_op_t op;
    logic [4:0] dst;
    logic [4:0] dst_hi;
    logic [4:0] src;
    logic [2:0] bsel;
    logic [11:0] k;
    logic [7:0] da;
    logic [7:0] sa;
    logic wr;
    logic wr_word;
    logic fl_upd;
    logic skip;
    op = cab_op_t'(pm_data_i[CAB_OP_HI:CAB_OP_LO]);
    dst = pm_data_i[CAB_DST_HI:CAB_DST_LO];
    dst_hi = dst + 5'h01;
    src = pm_data_i[CAB_SRC_HI:CAB_SRC_LO];
    bsel = pm_data_i[CAB_BIT_HI:CAB_BIT_LO];
    k = pm_data_i[CAB_K_HI:0];
    da = s.gpr[dst];
    sa = s.gpr[src];
    wr = 1'b0;
    wr_word = 1'b0;
    fl_upd = 1'b0;
    skip = 1'b0;
    next_s = s;
    next_s.push = 1'b0;
    next_s.pop = 1'b0;
    next_s.rdata = 8'h00;
    alu_bus.op = alu_add;
    alu_bus.a = da;
    alu_bus.b = sa;
    alu_bus.cin = 1'b0;
    alu_bus.aw = {s.gpr[dst_hi], da};

    unique case (s.st)
      st_exec: begin
        if (s.run) begin
          next_s.pc = s.pc + 16'h0001;
          case (op)
            op_add, op_add_carry: begin
              alu_bus.cin = (op == op_add_carry) & s.flags[CAB_FLG_C];
              wr = 1'b1;
              fl_upd = 1'b1;
            end
            op_word_add_imm, op_word_minus_imm: begin
              alu_bus.op = (op == op_word_add_imm) ? alu_wadd : alu_wsub;
              alu_bus.b = {2'b00, k[5:0]};
              wr_word = 1'b1;
              fl_upd = 1'b1;
              next_s.st = st_wait;
              next_s.wait_n = 2'(CAB_CYC_WORD - 1);
            end
            op_minus_reg, op_minus_imm, op_minus_carry_reg, op_minus_carry_imm: begin
              alu_bus.op = alu_sub;
              alu_bus.b = (op == op_minus_imm || op == op_minus_carry_imm) ? k[7:0] : sa;
              alu_bus.cin = (op == op_minus_carry_reg || op == op_minus_carry_imm) & s.flags[CAB_FLG_C];
              wr = 1'b1;
              fl_upd = 1'b1;
            end
            op_and_reg, op_conj_imm, op_clear_mask_bits, op_zero_sign_check: begin
              alu_bus.op = alu_and;
              if (op == op_conj_imm) begin
                alu_bus.b = k[7:0];
              end else if (op == op_clear_mask_bits) begin
                alu_bus.b = 8'hFF - k[7:0];
              end else if (op == op_zero_sign_check) begin
                alu_bus.b = da;
              end
              wr = (op != op_zero_sign_check);
              fl_upd = 1'b1;
            end
            op_or_reg, op_disj_imm, op_set_mask_bits: begin
              alu_bus.op = alu_or;
              alu_bus.b = (op == op_or_reg) ? sa : k[7:0];
              wr = 1'b1;
              fl_upd = 1'b1;
            end
            op_xor_reg, op_zero_reg: begin
              alu_bus.op = alu_xor;
              alu_bus.b = (op == op_zero_reg) ? da : sa;
              wr = 1'b1;
              fl_upd = 1'b1;
            end
            op_bitwise_invert, op_arith_invert, op_plus_one, op_minus_one: begin
              unique case (op)
                op_bitwise_invert: alu_bus.op = alu_inv;
                op_arith_invert: alu_bus.op = alu_negate;
                op_plus_one: alu_bus.op = alu_inc;
                default: alu_bus.op = alu_decr;
              endcase
              wr = 1'b1;
              fl_upd = 1'b1;
            end
            op_all_ones_reg: begin
              next_s.gpr[dst] = 8'hFF;
            end
            op_rel_jump, op_ptr_jump: begin
              next_s.pc = (op == op_rel_jump) ? cab_rel(s.pc, k) : {s.gpr[CAB_Z_HI], s.gpr[CAB_Z_LO]};
              next_s.st = st_wait;
              next_s.wait_n = 2'(CAB_CYC_JUMP - 1);
            end
            op_rel_subroutine_call, op_ptr_subroutine_call: begin
              next_s.pc = (op == op_rel_subroutine_call) ? cab_rel(s.pc, k) :
                          {s.gpr[CAB_Z_HI], s.gpr[CAB_Z_LO]};
              next_s.push = 1'b1;
              next_s.push_data = s.pc + 16'h0001;
              next_s.st = st_wait;
              next_s.wait_n = 2'(CAB_CYC_CALL - 1);
            end
            op_proc_exit, op_irq_exit: begin
              next_s.pop = 1'b1;
              next_s.st = st_pop;
              if (op == op_irq_exit) begin
                next_s.flags[CAB_FLG_I] = 1'b1;
              end
            end
            op_equal_skip: begin
              skip = (da == sa);
            end
            op_comparison, op_comparison_carry, op_comparison_imm: begin
              alu_bus.op = alu_sub;
              alu_bus.b = (op == op_comparison_imm) ? k[7:0] : sa;
              alu_bus.cin = (op == op_comparison_carry) & s.flags[CAB_FLG_C];
              fl_upd = 1'b1;
            end
            op_reg_bit_clear_skip, op_reg_bit_set_skip: begin
              skip = (sa[bsel] == (op == op_reg_bit_set_skip));
            end
            op_io_bit_clear_skip, op_io_bit_set_skip: begin
              // The five-bit port field cannot name any register above the bit-accessible range.
              skip = (io_low_i[src][bsel] == (op == op_io_bit_set_skip));
            end
            op_flag_set_branch, op_flag_clear_branch: begin
              if (s.flags[bsel] == (op == op_flag_set_branch)) begin
                next_s.pc = cab_rel(s.pc, k);
                next_s.st = st_wait;
                next_s.wait_n = 2'(CAB_CYC_TAKEN - 1);
              end
            end
            default: begin
              // Unused codes advance the program counter and change nothing else.
              next_s.pc = s.pc + 16'h0001;
            end
          endcase
          if (skip) begin
            next_s.st = st_skip;
          end
          if (wr) begin
            next_s.gpr[dst] = alu_bus.res[7:0];
          end
          if (wr_word) begin
            next_s.gpr[dst] = alu_bus.res[7:0];
            next_s.gpr[dst_hi] = alu_bus.res[15:8];
          end
          if (fl_upd) begin
            // Only the flags in the unit's mask change; all others keep their value.
            next_s.flags = (s.flags & ~alu_bus.fmask) | (alu_bus.fl & alu_bus.fmask);
          end
        end
      end
      st_wait: begin
        next_s.wait_n = s.wait_n - 2'd1;
        if (s.wait_n == 2'd1) begin
          next_s.st = st_exec;
        end
      end
      st_skip: begin
        // The program memory now shows the skipped word, so its length decides the extra cycle.
        if (pm_data_i[CAB_LONG_BIT]) begin
          next_s.pc = s.pc + 16'h0002;
          next_s.st = st_wait;
          next_s.wait_n = 2'd1;
        end else begin
          next_s.pc = s.pc + 16'h0001;
          next_s.st = st_exec;
        end
      end
      st_pop: begin
        next_s.pc = stack_top_i;
        next_s.st = st_wait;
        next_s.wait_n = 2'(CAB_CYC_RETURN - 2);
      end
    endcase

    // Port writes land after the core's own update, so software wins a same-cycle clash.
    if (bus_wr_i) begin
      if (bus_addr_i == CAB_REG_CTRL) begin
        next_s.run = bus_wdata_i[0];
      end else if (bus_addr_i == CAB_REG_FLAGS) begin
        next_s.flags = bus_wdata_i;
      end else if (bus_addr_i == CAB_REG_PC_LO) begin
        next_s.pc[7:0] = bus_wdata_i;
      end else if (bus_addr_i == CAB_REG_PC_HI) begin
        next_s.pc[15:8] = bus_wdata_i;
      end else if (bus_addr_i[7:5] == CAB_REG_GPR_PAGE) begin
        next_s.gpr[bus_addr_i[4:0]] = bus_wdata_i;
      end
    end
    if (bus_rd_i) begin
      next_s.rdata = cab_reg_rd(s, bus_addr_i);
    end
  end

  always_ff @(posedge clk_i or negedge rst_q[1]) begin
    if (!rst_q[1]) begin
      s <= '0;
      s.st <= st_exec;
      s.run <= CAB_RUN_RST;
      s.pc <= CAB_PC_RST;
      s.flags <= CAB_FLAGS_RST;
    end else begin
      s <= next_s;
    end
  end

  assign pm_addr_o = s.pc;
  assign stack_push_o = s.push;
  assign stack_pop_o = s.pop;
  assign stack_data_o = s.push_data;
  assign irq_enable_o = s.flags[CAB_FLG_I];
  assign bus_rdata_o = s.rdata;

endmodule
`default_nettype wire

/* File: dv/cab_pm_model.sv */
// Program memory and return stack model facing the execution core.
`timescale 1ns/1ps
`default_nettype none
module cab_pm_model (
  input wire logic clk_i,
  input wire logic [15:0] pm_addr_i,
  output logic [31:0] pm_data_o,
  input wire logic stack_push_i,
  input wire logic stack_pop_i,
  input wire logic [15:0] stack_data_i,
  output logic [15:0] stack_top_o
);
  logic [31:0] mem [64];
  logic [15:0] stk [$];
  logic [15:0] push_log [$];
  initial begin
    foreach (mem[i]) mem[i] = 32'h0000_0000;
  end
  // A runaway fetch past the image sees a changing pattern rather than a steady word.
  assign pm_data_o = (pm_addr_i < 16'd64) ? mem[pm_addr_i[5:0]] : ~{2{pm_addr_i}};
  // An empty stack shows a marker value so a pop without a push cannot land on address zero.
  always @(posedge clk_i) begin
    if (stack_push_i) begin
      stk.push_back(stack_data_i);
      push_log.push_back(stack_data_i);
    end
    if (stack_pop_i && stk.size() > 0) begin
      void'(stk.pop_back());
    end
    stack_top_o <= (stk.size() > 0) ? stk[$] : 16'hA5A5;
  end
endmodule
`default_nettype wire

/* File: dv/cab_core_asserts.sv */
// Concurrent checks on the ports of the execution core.
`timescale 1ns/1ps
`default_nettype none
module cab_core_asserts
  import cab_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [31:0] pm_data_i,
  input wire logic [31:0][7:0] io_low_i,
  input wire logic [15:0] stack_top_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [15:0] pm_addr_o,
  input wire logic stack_push_o,
  input wire logic stack_pop_o,
  input wire logic [15:0] stack_data_o,
  input wire logic irq_enable_o,
  input wire logic [7:0] bus_rdata_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [7:0] pc_lo_q;
  always_ff @(posedge clk_i) begin
    pc_lo_q <= pm_addr_o[7:0];
  end
  property p_push_pulse;
    stack_push_o |=> !stack_push_o;
  endproperty
  a_push_pulse: assert property (p_push_pulse) else $error("push longer than one cycle");
  property p_push_data;
    stack_push_o |-> stack_data_o == $past(pm_addr_o) + 16'h0001;
  endproperty
  a_push_data: assert property (p_push_data) else $error("wrong return address pushed");
  property p_push_hold;
    stack_push_o |=> $stable(pm_addr_o) ##1 $stable(pm_addr_o);
  endproperty
  a_push_hold: assert property (p_push_hold) else $error("call ended early");
  property p_pop_load;
    stack_pop_o |=> pm_addr_o == $past(stack_top_i);
  endproperty
  a_pop_load: assert property (p_pop_load) else $error("pc not loaded from stack");
  property p_pop_hold;
    stack_pop_o |=> !stack_pop_o ##1 $stable(pm_addr_o) ##1 $stable(pm_addr_o);
  endproperty
  a_pop_hold: assert property (p_pop_hold) else $error("return ended early");
  property p_irq_pop;
    $rose(irq_enable_o) && !$past(bus_wr_i) |-> stack_pop_o;
  endproperty
  a_irq_pop: assert property (p_irq_pop) else $error("interrupt enable set without return");
  property p_push_pop;
    !(stack_push_o && stack_pop_o);
  endproperty
  a_push_pop: assert property (p_push_pop) else $error("push and pop together");
  property p_rdata_idle;
    !bus_rd_i |=> bus_rdata_o == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without a read");
  property p_rd_pc;
    bus_rd_i && bus_addr_i == CAB_REG_PC_LO |=> bus_rdata_o == pc_lo_q;
  endproperty
  a_rd_pc: assert property (p_rd_pc) else $error("pc read mismatch");
  property p_rd_flag_i;
    bus_rd_i && bus_addr_i == CAB_REG_FLAGS |=> bus_rdata_o[CAB_FLG_I] == $past(irq_enable_o);
  endproperty
  a_rd_flag_i: assert property (p_rd_flag_i) else $error("interrupt flag read mismatch");
  c_push: cover property (stack_push_o);
  c_pop: cover property (stack_pop_o);
  c_irq: cover property ($rose(irq_enable_o));
endmodule
bind cab_core cab_core_asserts u_asserts (.clk_i(clk_i), .rst_b_i(rst_b_i), .pm_data_i(pm_data_i),
  .io_low_i(io_low_i), .stack_top_i(stack_top_i), .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i),
  .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .pm_addr_o(pm_addr_o), .stack_push_o(stack_push_o),
  .stack_pop_o(stack_pop_o), .stack_data_o(stack_data_o), .irq_enable_o(irq_enable_o),
  .bus_rdata_o(bus_rdata_o));
`default_nettype wire

/* File: dv/cab_core_tb.sv */
// Self-checking bench for the execution core.
`timescale 1ns/1ps
`default_nettype none
module cab_core_tb;
  import cab_pkg::*;
  typedef struct packed {cab_op_t op; logic [7:0] a, b, fin, res, hi, fl;} cab_tv_t;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [31:0] pm_data_i;
  logic [31:0][7:0] io_low_i = '0;
  logic [15:0] stack_top_i, pm_addr_o, stack_data_o;
  logic [7:0] bus_addr_i = 8'h00;
  logic [7:0] bus_wdata_i = 8'h00;
  logic bus_wr_i = 1'b0;
  logic bus_rd_i = 1'b0;
  logic stack_push_o, stack_pop_o, irq_enable_o;
  logic [7:0] bus_rdata_o;
  logic [15:0] got [31];
  int num_errors = 0;
  int cmp_count = 0;
  // The return's pop cycle already shows the address after the return word.
  int exp_tr [31] = '{1, 2, 3, 4, 6, 6, 7, 8, 9, 10, 11, 14, 14, 15, 20, 20, 20, 21, 16, 16, 16,
    24, 24, 24, 25, 17, 17, 17, 18, 25, 25};
  cab_tv_t tv [25] = '{
    '{op_add, 8'hFF, 8'h01, 8'h00, 8'h00, 8'h01, 8'h23},
    '{op_add_carry, 8'h7F, 8'h00, 8'h01, 8'h80, 8'h00, 8'h2C},
    '{op_word_add_imm, 8'hFF, 8'h01, 8'h20, 8'h00, 8'h02, 8'h20},
    '{op_word_minus_imm, 8'h00, 8'h01, 8'h1F, 8'hFF, 8'h00, 8'h00},
    '{op_minus_reg, 8'h10, 8'h01, 8'h00, 8'h0F, 8'h01, 8'h20},
    '{op_minus_imm, 8'h00, 8'h01, 8'h00, 8'hFF, 8'h01, 8'h25},
    '{op_minus_carry_reg, 8'h80, 8'h00, 8'h01, 8'h7F, 8'h00, 8'h28},
    '{op_minus_carry_imm, 8'h05, 8'h03, 8'h01, 8'h01, 8'h03, 8'h00},
    '{op_and_reg, 8'hF0, 8'h0F, 8'h01, 8'h00, 8'h0F, 8'h03},
    '{op_conj_imm, 8'h8F, 8'hF0, 8'h28, 8'h80, 8'hF0, 8'h24},
    '{op_or_reg, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h02},
    '{op_disj_imm, 8'h01, 8'h80, 8'h00, 8'h81, 8'h80, 8'h04},
    '{op_xor_reg, 8'hFF, 8'h0F, 8'h10, 8'hF0, 8'h0F, 8'h14},
    '{op_set_mask_bits, 8'h10, 8'h03, 8'h41, 8'h13, 8'h03, 8'h41},
    '{op_clear_mask_bits, 8'h13, 8'h13, 8'h00, 8'h00, 8'h13, 8'h02},
    '{op_zero_sign_check, 8'h80, 8'h00, 8'h02, 8'h80, 8'h00, 8'h04},
    '{op_bitwise_invert, 8'h55, 8'h00, 8'h20, 8'hAA, 8'h00, 8'h25},
    '{op_arith_invert, 8'h01, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h25},
    '{op_plus_one, 8'h7F, 8'h00, 8'h01, 8'h80, 8'h00, 8'h0D},
    '{op_minus_one, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02},
    '{op_zero_reg, 8'h5A, 8'h00, 8'h0C, 8'h00, 8'h00, 8'h02},
    '{op_all_ones_reg, 8'h00, 8'h00, 8'h3F, 8'hFF, 8'h00, 8'h3F},
    '{op_comparison, 8'h05, 8'h05, 8'h00, 8'h05, 8'h05, 8'h02},
    '{op_comparison_carry, 8'h05, 8'h05, 8'h01, 8'h05, 8'h05, 8'h25},
    '{op_comparison_imm, 8'h10, 8'h20, 8'h00, 8'h10, 8'h20, 8'h05}};
  always #25 clk_i = ~clk_i;
  cab_core DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .pm_data_i(pm_data_i), .io_low_i(io_low_i),
    .stack_top_i(stack_top_i), .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i),
    .bus_rd_i(bus_rd_i), .pm_addr_o(pm_addr_o), .stack_push_o(stack_push_o), .stack_pop_o(stack_pop_o),
    .stack_data_o(stack_data_o), .irq_enable_o(irq_enable_o), .bus_rdata_o(bus_rdata_o));
  cab_pm_model PM (.clk_i(clk_i), .pm_addr_i(pm_addr_o), .pm_data_o(pm_data_i), .stack_push_i(stack_push_o),
    .stack_pop_i(stack_pop_o), .stack_data_i(stack_data_o), .stack_top_o(stack_top_i));
  function automatic logic [31:0] enc(cab_op_t op, logic [4:0] d, logic [4:0] s, logic [2:0] b,
      logic [11:0] k, logic lng = 1'b0);
    return {op, lng, d, s, b, k};
  endfunction
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus_wr_i <= 1'b1;
    bus_addr_i <= a;
    bus_wdata_i <= d;
    @(posedge clk_i);
    bus_wr_i <= 1'b0;
  endtask
  task automatic check8(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    bus_rd_i <= 1'b1;
    bus_addr_i <= a;
    @(posedge clk_i);
    bus_rd_i <= 1'b0;
    #1 cmp({8'h00, bus_rdata_o}, {8'h00, e});
  endtask
  task automatic tally_and_finish();
    $display("Errors %0d, comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    io_low_i[3] = 8'h01;
    PM.mem[0] = enc(op_equal_skip, 5'd16, 5'd17, 3'd0, 12'h000);
    PM.mem[2] = enc(op_equal_skip, 5'd16, 5'd18, 3'd0, 12'h000);
    PM.mem[3] = enc(op_reg_bit_set_skip, 5'd0, 5'd18, 3'd7, 12'h000);
    PM.mem[4] = enc(op_nop, 5'd0, 5'd0, 3'd0, 12'h000, 1'b1);
    PM.mem[6] = enc(op_io_bit_set_skip, 5'd0, 5'd3, 3'd0, 12'h000);
    PM.mem[8] = enc(op_io_bit_clear_skip, 5'd0, 5'd3, 3'd0, 12'h000);
    PM.mem[9] = enc(op_reg_bit_clear_skip, 5'd0, 5'd18, 3'd0, 12'h000);
    PM.mem[11] = enc(op_flag_set_branch, 5'd0, 5'd0, 3'd0, 12'h002);
    PM.mem[14] = enc(op_flag_clear_branch, 5'd0, 5'd0, 3'd0, 12'h002);
    PM.mem[15] = enc(op_rel_subroutine_call, 5'd0, 5'd0, 3'd0, 12'h004);
    PM.mem[16] = enc(op_ptr_subroutine_call, 5'd0, 5'd0, 3'd0, 12'h000);
    PM.mem[17] = enc(op_plus_one, 5'd30, 5'd0, 3'd0, 12'h000);
    PM.mem[18] = enc(op_ptr_jump, 5'd0, 5'd0, 3'd0, 12'h000);
    PM.mem[20] = enc(op_proc_exit, 5'd0, 5'd0, 3'd0, 12'h000);
    PM.mem[24] = enc(op_irq_exit, 5'd0, 5'd0, 3'd0, 12'h000);
    PM.mem[25] = enc(op_rel_jump, 5'd0, 5'd0, 3'd0, 12'hFFF);
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check8(CAB_REG_PC_LO, 8'h00);
    check8(CAB_REG_FLAGS, 8'h00);
    check8(CAB_REG_CTRL, 8'h00);
    check8(8'h30, 8'h00);
    bus_wr(8'h10, 8'h5A);
    check8(8'h10, 8'h00);
    bus_wr(8'h30, 8'h05);
    bus_wr(8'h31, 8'h05);
    bus_wr(8'h32, 8'h80);
    bus_wr(8'h3E, 8'h18);
    bus_wr(8'h3F, 8'h00);
    bus_wr(CAB_REG_FLAGS, 8'h01);
    bus_wr(CAB_REG_CTRL, 8'h01);
    for (int n = 0; n < 10 && pm_addr_o !== 16'h0001; n++) @(negedge clk_i);
    for (int n = 0; n < 31; n++) begin
      got[n] = pm_addr_o;
      @(negedge clk_i);
    end
    bus_wr(CAB_REG_CTRL, 8'h00);
    foreach (got[n]) cmp(got[n], 16'(exp_tr[n]));
    cmp(16'(PM.push_log.size()), 16'h0002);
    cmp(PM.push_log[0], 16'h0010);
    cmp(PM.push_log[1], 16'h0011);
    cmp({15'h0000, irq_enable_o}, 16'h0001);
    check8(CAB_REG_FLAGS, 8'h81);
    check8(8'h3E, 8'h19);
    PM.mem[1] = enc(op_rel_jump, 5'd0, 5'd0, 3'd0, 12'hFFF);
    foreach (tv[i]) begin
      PM.mem[0] = enc(tv[i].op, 5'd16, 5'd17, 3'd0, {4'h0, tv[i].b});
      bus_wr(8'h30, tv[i].a);
      bus_wr(8'h31, tv[i].b);
      bus_wr(CAB_REG_FLAGS, tv[i].fin);
      bus_wr(CAB_REG_PC_LO, 8'h00);
      bus_wr(CAB_REG_PC_HI, 8'h00);
      bus_wr(CAB_REG_CTRL, 8'h01);
      repeat (4) @(posedge clk_i);
      bus_wr(CAB_REG_CTRL, 8'h00);
      check8(8'h30, tv[i].res);
      check8(8'h31, tv[i].hi);
      check8(CAB_REG_FLAGS, tv[i].fl);
      check8(CAB_REG_PC_LO, 8'h01);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
